// *** logic/pdmach_pkg.sv ***
package pdmach_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] OFS_RX_ADDR      = 12'h100;
    localparam logic [11:0] OFS_RX_CNT       = 12'h104;
    localparam logic [11:0] OFS_TX_ADDR      = 12'h108;
    localparam logic [11:0] OFS_TX_CNT       = 12'h10c;
    localparam logic [11:0] OFS_RX_Q_ADDR    = 12'h110;
    localparam logic [11:0] OFS_RX_Q_CNT     = 12'h114;
    localparam logic [11:0] OFS_TX_Q_ADDR    = 12'h118;
    localparam logic [11:0] OFS_TX_Q_CNT     = 12'h11c;
    localparam logic [11:0] OFS_COMMAND      = 12'h120;
    localparam logic [11:0] OFS_ENABLE_STATE = 12'h124;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W        = 16;
    localparam int          BIT_RX_ON    = 0;
    localparam int          BIT_RX_OFF   = 1;
    localparam int          BIT_TX_ON    = 8;
    localparam int          BIT_TX_OFF   = 9;
    localparam int          BIT_RX_STATE = 0;
    localparam int          BIT_TX_STATE = 8;
    localparam logic [31:0] PTR_RESET    = 32'h0;
    localparam logic [15:0] CNT_RESET    = 16'h0;
    localparam logic [15:0] CNT_ONE      = 16'h1;
    localparam logic [31:0] DATA_ZERO    = 32'h0;

    // Transfer size encoding on the peripheral side
    localparam logic [1:0]  SIZE_BYTE = 2'h0;
    localparam logic [1:0]  SIZE_HALF = 2'h1;
    localparam logic [31:0] STEP_BYTE = 32'h1;
    localparam logic [31:0] STEP_HALF = 32'h2;
    localparam logic [31:0] STEP_WORD = 32'h4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RX_STORE,
        ST_TX_FETCH,
        ST_SETTLE
    } pdmach_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic [1:0]  size;
    } pdmach_mem_req_s;

    typedef struct packed {
        logic rx_buffer_done;
        logic rx_all_buffers_full;
        logic tx_buffer_done;
        logic tx_all_buffers_empty;
    } pdmach_flags_s;

    // Pointer advance per transfer; unused code 3 counts as a word
    function automatic logic [31:0] pdmach_step(input logic [1:0] size);
        if (size == SIZE_BYTE) begin
            return STEP_BYTE;
        end else if (size == SIZE_HALF) begin
            return STEP_HALF;
        end
        return STEP_WORD;
    endfunction : pdmach_step

endpackage : pdmach_pkg

// *** logic/pdmach_top.sv ***
module pdmach_top
    import pdmach_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pdmach_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        rx_ready,
    input  wire logic [31:0]                 rx_data,
    output logic                             rx_taken,
    input  wire logic                        tx_ready,
    output logic      [31:0]                 tx_data,
    output logic                             tx_load,
    input  wire logic [1:0]                  xfer_size,
    output pdmach_pkg::pdmach_mem_req_s      mem_req,
    output logic                             mem_valid,
    input  wire logic                        mem_done,
    input  wire logic [31:0]                 mem_rdata,
    output pdmach_pkg::pdmach_flags_s        flags
);
    import pdmach_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0]     rx_address;
    logic [15:0]     rx_remaining;
    logic [31:0]     tx_address;
    logic [15:0]     tx_remaining;
    logic [31:0]     rx_queued_address;
    logic [15:0]     rx_queued_size;
    logic [31:0]     tx_queued_address;
    logic [15:0]     tx_queued_size;
    logic            rx_on;
    logic            tx_on;
    logic            rx_buffer_done;
    logic            tx_buffer_done;
    pdmach_state_e   state;

    logic [31:0]     next_rx_address;
    logic [15:0]     next_rx_remaining;
    logic [31:0]     next_tx_address;
    logic [15:0]     next_tx_remaining;
    logic [31:0]     next_rx_queued_address;
    logic [15:0]     next_rx_queued_size;
    logic [31:0]     next_tx_queued_address;
    logic [15:0]     next_tx_queued_size;
    logic            next_rx_on;
    logic            next_tx_on;
    pdmach_state_e   next_state;
    logic [31:0]     rd_value;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire apb_wr    = psel && penable && pwrite;
    wire apb_setup = psel && !penable;
    wire hit_rx_a  = (paddr == OFS_RX_ADDR);
    wire hit_rx_c  = (paddr == OFS_RX_CNT);
    wire hit_tx_a  = (paddr == OFS_TX_ADDR);
    wire hit_tx_c  = (paddr == OFS_TX_CNT);
    wire hit_rq_a  = (paddr == OFS_RX_Q_ADDR);
    wire hit_rq_c  = (paddr == OFS_RX_Q_CNT);
    wire hit_tq_a  = (paddr == OFS_TX_Q_ADDR);
    wire hit_tq_c  = (paddr == OFS_TX_Q_CNT);
    wire hit_cmd   = (paddr == OFS_COMMAND);
    wire hit_state = (paddr == OFS_ENABLE_STATE);
    wire hit_any   = hit_rx_a || hit_rx_c || hit_tx_a || hit_tx_c || hit_rq_a
                   || hit_rq_c || hit_tq_a || hit_tq_c || hit_cmd || hit_state;

    wire wr_rx_a   = apb_wr && hit_rx_a;
    wire wr_rx_c   = apb_wr && hit_rx_c;
    wire wr_tx_a   = apb_wr && hit_tx_a;
    wire wr_tx_c   = apb_wr && hit_tx_c;
    wire wr_rq_a   = apb_wr && hit_rq_a;
    wire wr_rq_c   = apb_wr && hit_rq_c;
    wire wr_tq_a   = apb_wr && hit_tq_a;
    wire wr_tq_c   = apb_wr && hit_tq_c;
    wire wr_cmd    = apb_wr && hit_cmd;

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Command register holds nothing; reads of it return zero
    always_comb begin
        rd_value = DATA_ZERO;
        if (hit_rx_a) begin
            rd_value = rx_address;
        end else if (hit_rx_c) begin
            rd_value = {16'h0, rx_remaining};
        end else if (hit_tx_a) begin
            rd_value = tx_address;
        end else if (hit_tx_c) begin
            rd_value = {16'h0, tx_remaining};
        end else if (hit_rq_a) begin
            rd_value = rx_queued_address;
        end else if (hit_rq_c) begin
            rd_value = {16'h0, rx_queued_size};
        end else if (hit_tq_a) begin
            rd_value = tx_queued_address;
        end else if (hit_tq_c) begin
            rd_value = {16'h0, tx_queued_size};
        end else if (hit_state) begin
            rd_value[BIT_RX_STATE] = rx_on;
            rd_value[BIT_TX_STATE] = tx_on;
        end
    end

    // Read data captured in the setup cycle, so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= DATA_ZERO;
        end else if (apb_setup && !pwrite) begin
            prdata <= rd_value;
        end
    end

    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------
    // Receive is served before transmit when both are pending
    wire rx_can   = rx_on && (rx_remaining != CNT_RESET) && rx_ready;
    wire tx_can   = tx_on && (tx_remaining != CNT_RESET) && tx_ready;
    wire rx_fin   = (state == ST_RX_STORE) && mem_done;
    wire tx_fin   = (state == ST_TX_FETCH) && mem_done;
    // A count rewritten to zero mid-flight must not wrap
    wire rx_dec   = rx_fin && (rx_remaining != CNT_RESET);
    wire tx_dec   = tx_fin && (tx_remaining != CNT_RESET);
    wire rx_end   = rx_dec && (rx_remaining == CNT_ONE);
    wire tx_end   = tx_dec && (tx_remaining == CNT_ONE);
    wire [31:0] step = pdmach_step(mem_req.size);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (rx_can) begin
                    next_state = ST_RX_STORE;
                end else if (tx_can) begin
                    next_state = ST_TX_FETCH;
                end
            end
            ST_RX_STORE: begin
                if (mem_done) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_TX_FETCH: begin
                if (mem_done) begin
                    next_state = ST_SETTLE;
                end
            end
            // One idle cycle lets the peripheral drop its ready strobe
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            mem_valid <= 1'b0;
            mem_req   <= '0;
            rx_taken  <= 1'b0;
        end else begin
            state    <= next_state;
            rx_taken <= (state == ST_IDLE) && rx_can;
            if (state == ST_IDLE && rx_can) begin
                mem_valid <= 1'b1;
                mem_req   <= '{addr: rx_address, wdata: rx_data, write: 1'b1, size: xfer_size};
            end else if (state == ST_IDLE && tx_can) begin
                mem_valid <= 1'b1;
                mem_req   <= '{addr: tx_address, wdata: DATA_ZERO, write: 1'b0,
                               size: xfer_size};
            end else if (mem_done) begin
                mem_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= DATA_ZERO;
            tx_load <= 1'b0;
        end else begin
            tx_load <= tx_fin;
            if (tx_fin) begin
                tx_data <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pointer and counter update
    // ------------------------------------------------------------------
    // Software writes beat the engine's own update in the same cycle
    always_comb begin
        next_rx_address        = rx_address;
        next_rx_remaining      = rx_remaining;
        next_tx_address        = tx_address;
        next_tx_remaining      = tx_remaining;
        next_rx_queued_address = rx_queued_address;
        next_rx_queued_size    = rx_queued_size;
        next_tx_queued_address = tx_queued_address;
        next_tx_queued_size    = tx_queued_size;
        if (rx_dec) begin
            next_rx_address   = rx_address + step;
            next_rx_remaining = rx_remaining - CNT_ONE;
        end
        if (tx_dec) begin
            next_tx_address   = tx_address + step;
            next_tx_remaining = tx_remaining - CNT_ONE;
        end
        if (wr_rx_a) next_rx_address = pwdata;
        if (wr_rx_c) next_rx_remaining = pwdata[CNT_W-1:0];
        if (wr_tx_a) next_tx_address = pwdata;
        if (wr_tx_c) next_tx_remaining = pwdata[CNT_W-1:0];
        if (wr_rq_a) next_rx_queued_address = pwdata;
        if (wr_rq_c) next_rx_queued_size = pwdata[CNT_W-1:0];
        if (wr_tq_a) next_tx_queued_address = pwdata;
        if (wr_tq_c) next_tx_queued_size = pwdata[CNT_W-1:0];
        if (next_rx_remaining == CNT_RESET && next_rx_queued_size != CNT_RESET) begin
            next_rx_address     = next_rx_queued_address;
            next_rx_remaining   = next_rx_queued_size;
            next_rx_queued_size = CNT_RESET;
        end
        if (next_tx_remaining == CNT_RESET && next_tx_queued_size != CNT_RESET) begin
            next_tx_address     = next_tx_queued_address;
            next_tx_remaining   = next_tx_queued_size;
            next_tx_queued_size = CNT_RESET;
        end
    end

    // Disable bits are applied last so they win over enables
    always_comb begin
        next_rx_on = rx_on;
        next_tx_on = tx_on;
        if (wr_cmd && pwdata[BIT_RX_ON]) next_rx_on = 1'b1;
        if (wr_cmd && pwdata[BIT_RX_OFF]) next_rx_on = 1'b0;
        if (wr_cmd && pwdata[BIT_TX_ON]) next_tx_on = 1'b1;
        if (wr_cmd && pwdata[BIT_TX_OFF]) next_tx_on = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_address        <= PTR_RESET;
            rx_remaining      <= CNT_RESET;
            tx_address        <= PTR_RESET;
            tx_remaining      <= CNT_RESET;
            rx_queued_address <= PTR_RESET;
            rx_queued_size    <= CNT_RESET;
            tx_queued_address <= PTR_RESET;
            tx_queued_size    <= CNT_RESET;
            rx_on             <= 1'b0;
            tx_on             <= 1'b0;
        end else begin
            rx_address        <= next_rx_address;
            rx_remaining      <= next_rx_remaining;
            tx_address        <= next_tx_address;
            tx_remaining      <= next_tx_remaining;
            rx_queued_address <= next_rx_queued_address;
            rx_queued_size    <= next_rx_queued_size;
            tx_queued_address <= next_tx_queued_address;
            tx_queued_size    <= next_tx_queued_size;
            rx_on             <= next_rx_on;
            tx_on             <= next_tx_on;
        end
    end

    // ------------------------------------------------------------------
    // End flags
    // ------------------------------------------------------------------
    // A buffer end in the same cycle as a count write still sets the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_done <= 1'b0;
            tx_buffer_done <= 1'b0;
        end else begin
            rx_buffer_done <= rx_end || (rx_buffer_done && !(wr_rx_c || wr_rq_c));
            tx_buffer_done <= tx_end || (tx_buffer_done && !(wr_tx_c || wr_tq_c));
        end
    end

    assign flags.rx_buffer_done       = rx_buffer_done;
    assign flags.tx_buffer_done       = tx_buffer_done;
    assign flags.rx_all_buffers_full  = (rx_remaining == CNT_RESET)
                                      && (rx_queued_size == CNT_RESET);
    assign flags.tx_all_buffers_empty = (tx_remaining == CNT_RESET)
                                      && (tx_queued_size == CNT_RESET);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rx_cmd_on: assert property (wr_cmd && pwdata[BIT_RX_ON] && !pwdata[BIT_RX_OFF]
        |=> rx_on) else $error("receive enable not applied");
    a_rx_off_wins: assert property (wr_cmd && pwdata[BIT_RX_OFF] |=> !rx_on)
        else $error("receive disable lost");
    a_rx_off_quiet: assert property (!rx_on |=> !rx_taken)
        else $error("receive taken while disabled");
    a_tx_cmd_on: assert property (wr_cmd && pwdata[BIT_TX_ON] && !pwdata[BIT_TX_OFF]
        |=> tx_on) else $error("transmit enable not applied");
    a_tx_off_wins: assert property (wr_cmd && pwdata[BIT_TX_OFF] |=> !tx_on)
        else $error("transmit disable lost");
    a_cmd_zero_keeps: assert property (wr_cmd && pwdata[BIT_TX_OFF:BIT_TX_ON] == 2'h0
        |=> $stable(tx_on)) else $error("zero command changed transmit state");
    a_state_readback: assert property (apb_setup && !pwrite && hit_state
        |=> prdata == ({23'h0, $past(tx_on), 7'h0, $past(rx_on)}))
        else $error("enable state read wrong");
    a_no_tx_at_zero: assert property (state == ST_IDLE && tx_remaining == CNT_RESET
        |=> state != ST_TX_FETCH) else $error("transmit with zero count");
    a_rx_step: assert property (rx_dec && rx_remaining > CNT_ONE && !apb_wr
        |=> rx_address == $past(rx_address) + $past(step)
            && rx_remaining == $past(rx_remaining) - CNT_ONE)
        else $error("receive pointer or count step wrong");
    a_tx_step: assert property (tx_dec && tx_remaining > CNT_ONE && !apb_wr
        |=> tx_address == $past(tx_address) + $past(step)
            && tx_remaining == $past(tx_remaining) - CNT_ONE)
        else $error("transmit pointer or count step wrong");
    a_rx_reload: assert property (rx_end && rx_queued_size != CNT_RESET && !apb_wr
        |=> rx_remaining == $past(rx_queued_size) && rx_queued_size == CNT_RESET
            && rx_address == $past(rx_queued_address))
        else $error("receive reload wrong");
    a_tx_reload: assert property (tx_end && tx_queued_size != CNT_RESET && !apb_wr
        |=> tx_remaining == $past(tx_queued_size) && tx_queued_size == CNT_RESET
            && tx_address == $past(tx_queued_address))
        else $error("transmit reload wrong");
    a_end_flag_set: assert property (tx_end |=> tx_buffer_done ##1 (tx_buffer_done
        || $past(wr_tx_c || wr_tq_c))) else $error("transmit end flag missing");
    a_cnt_wr_clear: assert property ((wr_rx_c || wr_rq_c) && !rx_end |=> !rx_buffer_done)
        else $error("receive end flag not cleared");
    a_tx_cnt_clear: assert property ((wr_tx_c || wr_tq_c) && !tx_end |=> !tx_buffer_done)
        else $error("transmit end flag not cleared");
    a_unmapped_err: assert property (psel && penable |-> pready
        && pslverr == (paddr < OFS_RX_ADDR || paddr > OFS_ENABLE_STATE || paddr[1:0] != 2'h0))
        else $error("unmapped access answer wrong");

    c_rx_xfer: cover property (rx_fin);
    c_tx_xfer: cover property (tx_fin ##1 tx_load);
    c_reload: cover property (rx_end && rx_queued_size != CNT_RESET);
    c_tx_reload: cover property (tx_end && tx_queued_size != CNT_RESET);
    c_both_cmd: cover property (wr_cmd && pwdata[BIT_RX_ON] && pwdata[BIT_RX_OFF]);

endmodule : pdmach_top

// *** tb/pdmach_partner.sv ***
module pdmach_partner
    import pdmach_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        rx_want,
    input  wire logic                        tx_want,
    input  wire logic [3:0]                  mem_lat,
    output logic                             rx_ready,
    output logic      [31:0]                 rx_data,
    input  wire logic                        rx_taken,
    output logic                             tx_ready,
    input  wire logic                        tx_load,
    input  wire pdmach_pkg::pdmach_mem_req_s mem_req,
    input  wire logic                        mem_valid,
    output logic                             mem_done,
    output logic      [31:0]                 mem_rdata,
    output logic      [31:0]                 wr_addr,
    output logic      [31:0]                 wr_data,
    output logic      [7:0]                  n_rx,
    output logic      [7:0]                  n_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Peripheral and memory
    // ------------------------------------------------------------------
    logic [3:0] wait_cnt;
    assign tx_ready = tx_want;
    // Ready drops right after a take so one datum is never seen twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ready <= 1'b0;
            rx_data  <= 32'ha000;
            n_rx     <= 8'h0;
            n_tx     <= 8'h0;
        end else begin
            rx_ready <= rx_want && !rx_taken;
            if (rx_taken) begin
                rx_data <= rx_data + 32'h1;
                n_rx    <= n_rx + 8'h1;
            end
            if (tx_load) begin
                n_tx <= n_tx + 8'h1;
            end
        end
    end
    // Read data toggles outside the done pulse so a stale value cannot pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_done  <= 1'b0;
            mem_rdata <= 32'h0;
            wait_cnt  <= 4'h0;
            wr_addr   <= 32'h0;
            wr_data   <= 32'h0;
        end else begin
            mem_done  <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_valid && !mem_done) begin
                if (wait_cnt == mem_lat) begin
                    mem_done  <= 1'b1;
                    wait_cnt  <= 4'h0;
                    mem_rdata <= ~mem_req.addr;
                    if (mem_req.write) begin
                        wr_addr <= mem_req.addr;
                        wr_data <= mem_req.wdata;
                    end
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule : pdmach_partner

// *** tb/test_peripheral_dma_channel_pair.sv ***
module test_peripheral_dma_channel_pair import pdmach_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pclk;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rx_data, tx_data, mem_rdata, wr_addr, wr_data;
    logic pready, pslverr, rx_ready, rx_taken, tx_ready, tx_load, mem_valid, mem_done;
    logic rx_want = 1'b0, tx_want = 1'b0;
    logic [1:0] xfer_size = 2'h0;
    logic [3:0] mem_lat = 4'h0;
    logic [7:0] n_rx, n_tx;
    pdmach_mem_req_s mem_req;
    pdmach_flags_s   flags;
    int error_cnt = 0, n_compared = 0;
    pdmach_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_ready(rx_ready), .rx_data(rx_data), .rx_taken(rx_taken),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_load(tx_load), .xfer_size(xfer_size),
        .mem_req(mem_req), .mem_valid(mem_valid), .mem_done(mem_done),
        .mem_rdata(mem_rdata), .flags(flags));
    pdmach_partner u_far (.pclk(pclk), .presetn(presetn), .rx_want(rx_want),
        .tx_want(tx_want), .mem_lat(mem_lat), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_taken(rx_taken), .tx_ready(tx_ready), .tx_load(tx_load), .mem_req(mem_req),
        .mem_valid(mem_valid), .mem_done(mem_done), .mem_rdata(mem_rdata),
        .wr_addr(wr_addr), .wr_data(wr_data), .n_rx(n_rx), .n_tx(n_tx));
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        int   n;
        logic map;
        map = (a >= OFS_RX_ADDR) && (a <= OFS_ENABLE_STATE) && (a[1:0] == 2'h0);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        chk("pslverr", 32'(pslverr), 32'(!map));
        chk("pready", 32'(pready), 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(a, 1'b0, 32'h0, q);
        chk($sformatf("reg_%h", a), q, exp);
    endtask : rd
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 10; i++) begin
            rd(12'h100 + 12'(4 * i), 32'h0);
        end
        rd(12'h128, 32'h0);
        rd(12'h0fc, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_regs();
        // Actives first: a queued count over an empty active one reloads at once
        for (int i = 0; i < 8; i++) begin
            wr(12'h100 + 12'(4 * i), 32'hffffffff);
        end
        for (int i = 0; i < 8; i++) begin
            rd(12'h100 + 12'(4 * i), i[0] ? 32'h0000ffff : 32'hffffffff);
        end
        wr(OFS_ENABLE_STATE, 32'hffffffff);
        rd(OFS_ENABLE_STATE, 32'h0);
        for (int i = 7; i >= 0; i--) begin
            wr(12'h100 + 12'(4 * i), 32'h0);
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_cmd();
        logic [31:0] cmd [9] = '{32'h101, 32'h0, 32'h3, 32'h1, 32'h300, 32'h100, 32'h200,
                                 32'h2, 32'hfffffcfc};
        logic [31:0] exp [9] = '{32'h101, 32'h101, 32'h100, 32'h101, 32'h1, 32'h101, 32'h1,
                                 32'h0, 32'h0};
        for (int i = 0; i < 9; i++) begin
            wr(OFS_COMMAND, cmd[i]);
            rd(OFS_ENABLE_STATE, exp[i]);
        end
        rd(OFS_COMMAND, 32'h0);
        $display("t_cmd done");
    endtask : t_cmd
    task automatic t_rx();
        wr(OFS_RX_ADDR, 32'h1000);
        wr(OFS_RX_CNT, 32'h2);
        wr(OFS_RX_Q_ADDR, 32'h2000);
        wr(OFS_RX_Q_CNT, 32'h1);
        xfer_size <= SIZE_HALF;
        rx_want   <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("rx_while_off", 32'(n_rx), 32'h0);
        wr(OFS_COMMAND, 32'h1 << BIT_RX_ON);
        for (int n = 0; n < 400 && !(n_rx == 8'h3 && mem_valid === 1'b0); n++) @(posedge pclk);
        repeat (10) @(posedge pclk);
        chk("rx_count", 32'(n_rx), 32'h3);
        chk("rx_wr_addr", wr_addr, 32'h2000);
        chk("rx_wr_data", wr_data, 32'ha002);
        rd(OFS_RX_ADDR, 32'h2002);
        rd(OFS_RX_CNT, 32'h0);
        rd(OFS_RX_Q_CNT, 32'h0);
        chk("rx_done", 32'(flags.rx_buffer_done), 32'h1);
        chk("rx_full", 32'(flags.rx_all_buffers_full), 32'h1);
        wr(OFS_RX_Q_CNT, 32'h0);
        chk("rx_done_clr", 32'(flags.rx_buffer_done), 32'h0);
        rx_want <= 1'b0;
        wr(OFS_COMMAND, 32'h1 << BIT_RX_OFF);
        $display("t_rx done");
    endtask : t_rx
    task automatic t_tx();
        mem_lat   <= 4'h3;
        xfer_size <= 2'h2;
        wr(OFS_TX_ADDR, 32'h3000);
        wr(OFS_TX_CNT, 32'h1);
        wr(OFS_TX_Q_ADDR, 32'h4000);
        wr(OFS_TX_Q_CNT, 32'h1);
        tx_want <= 1'b1;
        wr(OFS_COMMAND, 32'h1 << BIT_TX_ON);
        for (int n = 0; n < 400 && n_tx != 8'h2; n++) @(posedge pclk);
        repeat (10) @(posedge pclk);
        chk("tx_count", 32'(n_tx), 32'h2);
        chk("tx_data", tx_data, 32'hffffbfff);
        rd(OFS_TX_ADDR, 32'h4004);
        rd(OFS_TX_CNT, 32'h0);
        chk("tx_done", 32'(flags.tx_buffer_done), 32'h1);
        chk("tx_empty", 32'(flags.tx_all_buffers_empty), 32'h1);
        wr(OFS_TX_CNT, 32'h0);
        chk("tx_done_clr", 32'(flags.tx_buffer_done), 32'h0);
        xfer_size <= SIZE_BYTE;
        wr(OFS_TX_CNT, 32'h2);
        for (int n = 0; n < 400 && n_tx != 8'h4; n++) @(posedge pclk);
        repeat (10) @(posedge pclk);
        chk("tx_count_byte", 32'(n_tx), 32'h4);
        rd(OFS_TX_ADDR, 32'h4006);
        chk("tx_no_write", wr_addr, 32'h2000);
        $display("t_tx done");
    endtask : t_tx
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        t_cmd();
        t_rx();
        t_tx();
        report_and_stop();
    end
endmodule : test_peripheral_dma_channel_pair
